// [hw/prbs_defines.vh]
// register indices, field positions, reset values and limits of the self-test block
`ifndef PRBS_DEFINES_VH
`define PRBS_DEFINES_VH

// register indices; the byte address on the bus is four times the index
`define IDX_GEN_CTRL          12'h619
`define IDX_GEN_PACKET_LENGTH 12'h61a
`define IDX_GEN_IPG           12'h61b
`define IDX_CHK_BYTE_COUNT    12'h61c
`define IDX_CHK_PKT_LOW       12'h61d
`define IDX_CHK_PKT_HIGH      12'h61e
`define IDX_STATUS            12'h620
`define IDX_CHK_ERR_PKT_LOW   12'h622
`define IDX_GEN_PACKET_TARGET 12'h630

// control register fields
`define CTRL_GEN_ENABLE   0
`define CTRL_PRBS_MODE    1
`define CTRL_CHK_ENABLE   2
`define CTRL_COUNT_MODE   3
`define CTRL_SEND_PKT     12

// status register fields
`define ST_LOCK_CMD       0
`define ST_CLEAR_CMD      1
`define ST_IN_SYNC        8
`define ST_BYTE_OV        9
`define ST_PKT_OV         10
`define ST_BUSY           11
`define ST_DONE           12

// reset values
`define RST_PACKET_LENGTH 16'h05dc
`define RST_IPG           8'h7d
`define RST_PACKET_TARGET 16'h0001
`define RST_CTRL          16'h0004

// counter limits
`define MAX_BYTE_CNT      16'hffff
`define MAX_PKT_CNT       32'h0fffffff
`define MAX_ERR_PKT_CNT   32'h0fffffff
`define MAX_ERR_BIT_CNT   8'hff

// checker synchronisation and generator seed
`define SYNC_GOOD_BYTES   3'h4
`define SYNC_BAD_BYTES    3'h4
`define PRBS_SEED         8'hff

`endif

// [hw/prbs_gen_checker.v]
// packet/prbs test generator, receive checker with statistics, apb register file
`timescale 1ns/1ps
`include "prbs_defines.vh"

// ****************************************************************
// receive stream fifo
// ****************************************************************
module stream_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clock,
    input  wire             srst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage has no reset; only the pointers define the content
    always @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always @(posedge clock) begin
        if (srst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // stream_fifo

// ****************************************************************
// top: generator, checker, statistics
// ****************************************************************
module prbs_gen_checker (
    input  wire        clock,
    input  wire        srst,
    input  wire [15:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_last,
    input  wire        rx_valid,
    output wire        rx_ready,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    output reg         counter_wrap
);
    localparam ST_IDLE = 2'b00;
    localparam ST_DATA = 2'b01;
    localparam ST_GAP  = 2'b10;

    // configuration
    reg  [15:0] ctrl_reg;
    reg  [15:0] pkt_len_reg;
    reg  [7:0]  ipg_reg;
    reg  [15:0] pkt_target_reg;
    // generator
    reg  [1:0]  state_reg;
    reg  [15:0] byte_idx_reg;
    reg  [7:0]  gap_reg;
    reg  [15:0] pkt_sent_reg;
    reg  [7:0]  gen_lfsr_reg;
    reg         done_reg;
    // checker live counters and snapshots
    reg  [15:0] byte_cnt_reg;
    reg  [31:0] pkt_cnt_reg;
    reg  [31:0] err_pkt_cnt_reg;
    reg  [7:0]  err_bit_cnt_reg;
    reg  [15:0] snap_byte_reg;
    reg  [31:0] snap_pkt_reg;
    reg  [31:0] snap_err_pkt_reg;
    reg  [7:0]  snap_err_bit_reg;
    reg         byte_ov_reg;
    reg         pkt_ov_reg;
    reg  [7:0]  expect_reg;
    reg         in_sync_reg;
    reg  [2:0]  good_run_reg;
    reg  [2:0]  bad_run_reg;
    reg         pkt_err_reg;

    wire        wr_en;
    wire        rd_setup;
    wire [11:0] idx;
    wire        addr_ok;
    wire        count_mode;
    wire        gen_enable;
    wire        prbs_mode;
    wire        chk_enable;
    wire        lock_cmd;
    wire        clear_cmd;
    wire        fifo_valid;
    wire        fifo_ready;
    wire [8:0]  fifo_data;
    wire        take;
    wire        halted;
    wire        tx_fire;
    wire        last_byte;
    wire        mac_finish;
    wire [7:0]  diff;
    wire [3:0]  diff_bits;
    wire [8:0]  err_sum;
    wire        pkt_end;

    // one prbs step per byte, shared by generator and checker
    function [7:0] prbs_next;
        input [7:0] b;
        begin
            prbs_next = {b[6:0], b[7] ^ b[5] ^ b[4] ^ b[3]};
        end
    endfunction

    // number of ones in a byte, the errored bits of one received byte
    function [3:0] ones;
        input [7:0] b;
        integer i;
        begin
            ones = 4'h0;
            for (i = 0; i < 8; i = i + 1) begin
                ones = ones + {3'b000, b[i]};
            end
        end
    endfunction

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // zero wait states; read data is captured in the setup cycle
    assign pready     = 1'b1;
    assign idx        = paddr[13:2];
    assign addr_ok    = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00) &&
                        (idx == `IDX_GEN_CTRL || idx == `IDX_GEN_PACKET_LENGTH ||
                         idx == `IDX_GEN_IPG || idx == `IDX_CHK_BYTE_COUNT ||
                         idx == `IDX_CHK_PKT_LOW || idx == `IDX_CHK_PKT_HIGH ||
                         idx == `IDX_STATUS || idx == `IDX_CHK_ERR_PKT_LOW ||
                         idx == `IDX_GEN_PACKET_TARGET);
    assign wr_en      = psel & penable & pwrite & addr_ok;
    assign rd_setup   = psel & ~penable;
    assign lock_cmd   = wr_en & (idx == `IDX_STATUS) & pwdata[`ST_LOCK_CMD];
    assign clear_cmd  = wr_en & (idx == `IDX_STATUS) & pwdata[`ST_CLEAR_CMD];
    assign gen_enable = ctrl_reg[`CTRL_GEN_ENABLE];
    assign prbs_mode  = ctrl_reg[`CTRL_PRBS_MODE];
    assign chk_enable = ctrl_reg[`CTRL_CHK_ENABLE];
    assign count_mode = ctrl_reg[`CTRL_COUNT_MODE];

    // read mux; counters always read from the snapshot copies
    always @(posedge clock) begin
        if (srst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            pslverr <= ~addr_ok;
            prdata  <= 32'h00000000;
            if (!pwrite && addr_ok) begin
                case (idx)
                    `IDX_GEN_CTRL:          prdata <= {16'h0000, ctrl_reg};
                    `IDX_GEN_PACKET_LENGTH: prdata <= {16'h0000, pkt_len_reg};
                    `IDX_GEN_IPG:           prdata <= {24'h000000, ipg_reg};
                    `IDX_CHK_BYTE_COUNT:    prdata <= {16'h0000, snap_byte_reg};
                    `IDX_CHK_PKT_LOW:       prdata <= {16'h0000, snap_pkt_reg[15:0]};
                    `IDX_CHK_PKT_HIGH:      prdata <= {16'h0000, snap_pkt_reg[31:16]};
                    `IDX_CHK_ERR_PKT_LOW:   prdata <= {16'h0000, snap_err_pkt_reg[15:0]};
                    `IDX_GEN_PACKET_TARGET: prdata <= {16'h0000, pkt_target_reg};
                    `IDX_STATUS: begin
                        prdata <= {19'h00000, done_reg, state_reg != ST_IDLE,
                                   pkt_ov_reg, byte_ov_reg, in_sync_reg,
                                   snap_err_bit_reg};
                    end
                    default:                prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // software setting send wins over the generator clearing it
    always @(posedge clock) begin
        if (srst) begin
            ctrl_reg       <= `RST_CTRL;
            pkt_len_reg    <= `RST_PACKET_LENGTH;
            ipg_reg        <= `RST_IPG;
            pkt_target_reg <= `RST_PACKET_TARGET;
        end else begin
            if (mac_finish) begin
                ctrl_reg[`CTRL_SEND_PKT] <= 1'b0;
            end
            if (wr_en) begin
                case (idx)
                    `IDX_GEN_CTRL: begin
                        ctrl_reg <= {3'b000, pwdata[12], 8'h00, pwdata[3:0]};
                    end
                    `IDX_GEN_PACKET_LENGTH: pkt_len_reg    <= pwdata[15:0];
                    `IDX_GEN_IPG:           ipg_reg        <= pwdata[7:0];
                    `IDX_GEN_PACKET_TARGET: pkt_target_reg <= pwdata[15:0];
                    default:                pkt_len_reg    <= pkt_len_reg;
                endcase
            end
        end
    end

    // ****************************************************************
    // generator
    // ****************************************************************
    assign tx_fire    = tx_valid & tx_ready;
    assign last_byte  = (byte_idx_reg + 16'h0001 >= pkt_len_reg);
    // a zero target means endless mac packets
    assign mac_finish = tx_fire & last_byte & ~prbs_mode &
                        (pkt_target_reg != 16'h0000) &
                        (pkt_sent_reg + 16'h0001 == pkt_target_reg);

    // packet of pkt_len bytes, then ipg plus one idle byte times, until stopped
    always @(posedge clock) begin
        if (srst) begin
            state_reg    <= ST_IDLE;
            byte_idx_reg <= 16'h0000;
            gap_reg      <= 8'h00;
            pkt_sent_reg <= 16'h0000;
            gen_lfsr_reg <= `PRBS_SEED;
            done_reg     <= 1'b0;
            tx_valid     <= 1'b0;
            tx_data      <= 8'h00;
            tx_last      <= 1'b0;
        end else begin
            if (wr_en && idx == `IDX_GEN_CTRL && pwdata[`CTRL_SEND_PKT]) begin
                done_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    pkt_sent_reg <= 16'h0000;
                    if (gen_enable && (prbs_mode || ctrl_reg[`CTRL_SEND_PKT])) begin
                        state_reg    <= ST_DATA;
                        byte_idx_reg <= 16'h0000;
                        tx_valid     <= 1'b1;
                        tx_data      <= prbs_mode ? gen_lfsr_reg : 8'h00;
                        tx_last      <= (pkt_len_reg <= 16'h0001);
                    end
                end
                ST_DATA: begin
                    if (tx_fire) begin
                        gen_lfsr_reg <= prbs_next(gen_lfsr_reg);
                        if (last_byte) begin
                            tx_valid     <= 1'b0;
                            tx_last      <= 1'b0;
                            pkt_sent_reg <= pkt_sent_reg + 16'h0001;
                            gap_reg      <= ipg_reg;
                            if (mac_finish) begin
                                done_reg  <= 1'b1;
                                state_reg <= ST_IDLE;
                            end else begin
                                state_reg <= ST_GAP;
                            end
                        end else begin
                            byte_idx_reg <= byte_idx_reg + 16'h0001;
                            tx_data      <= prbs_mode ? prbs_next(gen_lfsr_reg) :
                                            byte_idx_reg[7:0] + 8'h01;
                            tx_last      <= (byte_idx_reg + 16'h0002 >= pkt_len_reg);
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_reg != 8'h00) begin
                        gap_reg <= gap_reg - 8'h01;
                    end else if (gen_enable && (prbs_mode || ctrl_reg[`CTRL_SEND_PKT])) begin
                        state_reg    <= ST_DATA;
                        byte_idx_reg <= 16'h0000;
                        tx_valid     <= 1'b1;
                        tx_data      <= prbs_mode ? gen_lfsr_reg : 8'h00;
                        tx_last      <= (pkt_len_reg <= 16'h0001);
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // receive fifo
    // ****************************************************************
    stream_fifo #(
        .WIDTH (9),
        .DEPTH (32),
        .AW    (5)
    ) u_rx_fifo (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_last, rx_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // ****************************************************************
    // checker
    // ****************************************************************
    // a halted checker stops draining, so the stream backs up to the source
    assign halted = ~count_mode & (byte_cnt_reg == `MAX_BYTE_CNT ||
                    pkt_cnt_reg == `MAX_PKT_CNT || err_pkt_cnt_reg == `MAX_ERR_PKT_CNT ||
                    err_bit_cnt_reg == `MAX_ERR_BIT_CNT);
    assign fifo_ready = ~(chk_enable & halted);
    assign take       = fifo_valid & fifo_ready & chk_enable;
    assign diff       = fifo_data[7:0] ^ expect_reg;
    assign diff_bits  = in_sync_reg ? ones(diff) : 4'h0;
    assign err_sum    = {1'b0, err_bit_cnt_reg} + {5'h00, diff_bits};
    assign pkt_end    = take & fifo_data[8];

    // self-synchronising: unlocked, the expected byte follows the received one
    always @(posedge clock) begin
        if (srst) begin
            expect_reg   <= 8'h00;
            in_sync_reg  <= 1'b0;
            good_run_reg <= 3'h0;
            bad_run_reg  <= 3'h0;
        end else if (take) begin
            if (diff == 8'h00) begin
                bad_run_reg  <= 3'h0;
                good_run_reg <= (good_run_reg == `SYNC_GOOD_BYTES) ? good_run_reg :
                                good_run_reg + 3'h1;
                if (good_run_reg + 3'h1 >= `SYNC_GOOD_BYTES) begin
                    in_sync_reg <= 1'b1;
                end
            end else begin
                good_run_reg <= 3'h0;
                bad_run_reg  <= (bad_run_reg == `SYNC_BAD_BYTES) ? bad_run_reg :
                                bad_run_reg + 3'h1;
                if (bad_run_reg + 3'h1 >= `SYNC_BAD_BYTES) begin
                    in_sync_reg <= 1'b0;
                end
            end
            expect_reg <= in_sync_reg ? prbs_next(expect_reg) : prbs_next(fifo_data[7:0]);
        end
    end

    // live counters; clear wins over counting, overflow set wins over clear
    always @(posedge clock) begin
        if (srst) begin
            byte_cnt_reg    <= 16'h0000;
            pkt_cnt_reg     <= 32'h00000000;
            err_pkt_cnt_reg <= 32'h00000000;
            err_bit_cnt_reg <= 8'h00;
            pkt_err_reg     <= 1'b0;
            byte_ov_reg     <= 1'b0;
            pkt_ov_reg      <= 1'b0;
            counter_wrap    <= 1'b0;
        end else begin
            counter_wrap <= 1'b0;
            // an overflow in the very cycle of a clear still shows afterwards
            if (clear_cmd) begin
                byte_ov_reg <= take & (byte_cnt_reg == `MAX_BYTE_CNT);
                pkt_ov_reg  <= pkt_end & (pkt_cnt_reg == `MAX_PKT_CNT);
            end
            if (clear_cmd) begin
                byte_cnt_reg    <= 16'h0000;
                pkt_cnt_reg     <= 32'h00000000;
                err_pkt_cnt_reg <= 32'h00000000;
                err_bit_cnt_reg <= 8'h00;
                pkt_err_reg     <= 1'b0;
            end else if (take) begin
                // bytes
                if (byte_cnt_reg == `MAX_BYTE_CNT) begin
                    byte_ov_reg  <= 1'b1;
                    counter_wrap <= 1'b1;
                    byte_cnt_reg <= 16'h0000;
                end else begin
                    byte_cnt_reg <= byte_cnt_reg + 16'h0001;
                end
                // errored bits
                // single mode clamps, even when one byte brings several error bits
                if (!count_mode && err_sum >= {1'b0, `MAX_ERR_BIT_CNT}) begin
                    err_bit_cnt_reg <= `MAX_ERR_BIT_CNT;
                end else if (err_sum > {1'b0, `MAX_ERR_BIT_CNT}) begin
                    counter_wrap    <= 1'b1;
                    err_bit_cnt_reg <= err_sum[7:0];
                end else begin
                    err_bit_cnt_reg <= err_sum[7:0];
                end
                // packets
                pkt_err_reg <= pkt_end ? 1'b0 : (pkt_err_reg | (diff_bits != 4'h0));
                if (pkt_end) begin
                    if (pkt_cnt_reg == `MAX_PKT_CNT) begin
                        pkt_ov_reg   <= 1'b1;
                        counter_wrap <= 1'b1;
                        pkt_cnt_reg  <= 32'h00000000;
                    end else begin
                        pkt_cnt_reg <= pkt_cnt_reg + 32'h00000001;
                    end
                    if (pkt_err_reg || diff_bits != 4'h0) begin
                        if (err_pkt_cnt_reg == `MAX_ERR_PKT_CNT) begin
                            counter_wrap    <= 1'b1;
                            err_pkt_cnt_reg <= 32'h00000000;
                        end else begin
                            err_pkt_cnt_reg <= err_pkt_cnt_reg + 32'h00000001;
                        end
                    end
                end
            end
        end
    end

    // snapshot copies seen by software; lock and lock-and-clear both load them
    always @(posedge clock) begin
        if (srst) begin
            snap_byte_reg    <= 16'h0000;
            snap_pkt_reg     <= 32'h00000000;
            snap_err_pkt_reg <= 32'h00000000;
            snap_err_bit_reg <= 8'h00;
        end else if (lock_cmd || clear_cmd) begin
            snap_byte_reg    <= byte_cnt_reg;
            snap_pkt_reg     <= pkt_cnt_reg;
            snap_err_pkt_reg <= err_pkt_cnt_reg;
            snap_err_bit_reg <= err_bit_cnt_reg;
        end
    end
endmodule // prbs_gen_checker

// [test/prbs_gen_checker_props.sv]
// port assertions for the self-test block
`timescale 1ns/1ps
`include "prbs_defines.vh"
module prbs_props (
    input wire        clock,
    input wire        srst,
    input wire [15:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire [7:0]  tx_data,
    input wire        tx_last
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ****************************************************************
    // bus answers
    // ****************************************************************
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_bad; psel && !penable && (paddr[1:0] != 2'h0 || paddr[15:14] != 2'h0) |=> pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("bad address accepted");
    property p_err_data; psel && penable && pslverr |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("refused read gave data");
    property p_wr_data; psel && penable && pwrite |-> prdata == 32'h0; endproperty
    a_wr_data: assert property (p_wr_data) else $error("write returned data");
    // ****************************************************************
    // generator stream; the bench never programs a gap below two
    // ****************************************************************
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte changed");
    property p_gap; tx_valid && tx_ready && tx_last |=> !tx_valid [*3]; endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
    property p_start; psel && penable && pwrite && paddr == {2'h0, `IDX_GEN_CTRL, 2'h0}
        && pwdata[0] && pwdata[12] |-> ##2 tx_valid; endproperty
    a_start: assert property (p_start) else $error("generator did not start");
    property p_clr; tx_valid && tx_ready && !tx_last |=> tx_valid || !tx_last; endproperty
    a_clr: assert property (p_clr) else $error("last flag without byte");
endmodule // prbs_props
bind prbs_gen_checker prbs_props prbs_props_i (.clock, .srst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_data, .tx_last);

// [test/prbs_gen_checker_stats_tb.sv]
// self-checking bench of the self-test block over apb
`timescale 1ns/1ps
`include "prbs_defines.vh"
`define A(i) {2'h0, i, 2'h0}
`define CHK(n, x, g) begin n_checks++; if ((g) !== (x)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", n, x, g); end end
module prbs_gen_checker_stats_tb;
    logic        clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic        tx_ready = 0, rx_valid = 0, rx_last = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [7:0]  rx_data = 0, lfsr = 8'hff;
    wire  [31:0] prdata;
    wire  [7:0]  tx_data;
    wire         pready, pslverr, tx_valid, tx_last, rx_ready, counter_wrap;
    int          miscompares = 0, n_checks = 0, cyc = 0, nb = 0, nw = 0;
    prbs_gen_checker prbs_gen_checker_i (.clock, .srst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .tx_data, .tx_last,
        .rx_valid, .rx_ready, .rx_data, .rx_last, .counter_wrap);
    initial forever #4 clock = ~clock;
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one transfer; the request stands until pready is seen at an edge
    task apb(input [15:0] a, input w, input [31:0] d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input [11:0] i, input [31:0] x, input string n);
        apb(`A(i), 0, 0);
        `CHK(n, x, r)
    endtask
    // one receive byte; the data lines are inverted once released
    task send(input [7:0] b, input l);
        @(posedge clock);
        rx_valid <= 1; rx_data <= b; rx_last <= l;
        do @(posedge clock); while (rx_ready !== 1'b1);
        rx_valid <= 0;
        rx_data <= ~b;
    endtask
    // n prbs bytes, packet end every eighth; flip corrupts the final byte, or every odd one
    task stream(input int n, input [7:0] flip, input bit alt = 0);
        for (int k = 1; k <= n; k++) begin
            send((alt ? k % 2 == 1 : k == n) ? lfsr ^ flip : lfsr, k % 8 == 0);
            lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
        repeat (4) @(posedge clock);
    endtask
    // stalling sink, framing of three-byte packets, and the hang limit
    always @(posedge clock) begin
        cyc++;
        tx_ready <= ~tx_ready;
        if (counter_wrap === 1'b1) nw++;
        if (tx_valid && tx_ready) begin
            `CHK("tx_last", nb % 3 == 2, tx_last)
            `CHK("tx_data", nb % 3, tx_data)
            nb++;
        end
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        srst <= 0;
        rd(`IDX_GEN_PACKET_LENGTH, 32'h5dc, "length");
        rd(`IDX_GEN_IPG, 32'h7d, "gap");
        rd(`IDX_GEN_CTRL, 32'h4, "ctrl");
        rd(`IDX_STATUS, 32'h0, "status");
        apb(`A(`IDX_GEN_IPG), 1, 32'hffff);
        rd(`IDX_GEN_IPG, 32'hff, "gap field");
        apb(`A(`IDX_CHK_BYTE_COUNT), 1, 32'h1234);
        rd(`IDX_CHK_BYTE_COUNT, 32'h0, "byte count");
        apb(16'h1871, 0, 0);
        `CHK("misaligned", 1'b1, e)
        apb(`A(12'h700), 0, 0);
        `CHK("unmapped", 33'h1_0000_0000, {e, r})
        $display("test registers done");
        apb(`A(`IDX_GEN_PACKET_LENGTH), 1, 32'h3);
        apb(`A(`IDX_GEN_IPG), 1, 32'h2);
        apb(`A(`IDX_GEN_PACKET_TARGET), 1, 32'h2);
        apb(`A(`IDX_GEN_CTRL), 1, 32'h1005);
        rd(`IDX_STATUS, 32'h800, "busy");
        for (int k = 0; k < 100 && r[12] !== 1'b1; k++) apb(`A(`IDX_STATUS), 0, 0);
        `CHK("done", 32'h1000, r)
        `CHK("bytes sent", 6, nb)
        rd(`IDX_GEN_CTRL, 32'h5, "send cleared");
        $display("test generator done");
        stream(16, 8'h0);
        apb(`A(`IDX_STATUS), 1, 32'h1);
        rd(`IDX_CHK_BYTE_COUNT, 32'h10, "bytes");
        rd(`IDX_CHK_PKT_LOW, 32'h2, "packets");
        rd(`IDX_CHK_PKT_HIGH, 32'h0, "packets high");
        rd(`IDX_STATUS, 32'h1100, "in sync");
        stream(8, 8'h01);
        rd(`IDX_CHK_BYTE_COUNT, 32'h10, "frozen");
        apb(`A(`IDX_STATUS), 1, 32'h2);
        rd(`IDX_CHK_BYTE_COUNT, 32'h18, "pre-clear");
        rd(`IDX_CHK_PKT_LOW, 32'h3, "pre-clear packets");
        rd(`IDX_CHK_ERR_PKT_LOW, 32'h1, "errored packets");
        rd(`IDX_STATUS, 32'h1101, "errored bits");
        apb(`A(`IDX_GEN_CTRL), 1, 32'hc);
        stream(64, 8'hff, 1);
        apb(`A(`IDX_STATUS), 1, 32'h1);
        rd(`IDX_CHK_BYTE_COUNT, 32'h40, "wrap bytes");
        rd(`IDX_STATUS, 32'h1100, "bits wrapped");
        `CHK("wrap pulses", 1, nw)
        apb(`A(`IDX_GEN_CTRL), 1, 32'h0);
        stream(8, 8'h0);
        apb(`A(`IDX_GEN_CTRL), 1, 32'h4);
        apb(`A(`IDX_STATUS), 1, 32'h1);
        rd(`IDX_CHK_BYTE_COUNT, 32'h40, "disabled");
        $display("test checker done");
        stop_test();
    end
endmodule // prbs_gen_checker_stats_tb
